// ==== common/tmr_pkg.sv ====
// constants and state types for the shared-prescaler timer/counter
// How it works
// RULE1: overflow flag sets when the count wraps from FFh to 00h.
// RULE2: clock source clear selects timer mode, one count per cycle without prescaler.
// RULE3: any write to the count blocks counting for the next two cycles.
// RULE4: clock source set selects counter mode, counting edges on the external pin.
// RULE5: edge select clear counts rising edges, set counts falling edges.
// RULE6: external pin is synchronised first; the far source must allow this.
// RULE7: one 8-bit prescaler, owned by either timer or watchdog, never both.
// RULE8: software can neither read nor load the prescaler count.
// RULE9: assign clear feeds the timer with ratios 1:2 up to 1:256.
// RULE10: assign set serves the watchdog with ratios 1:1 up to 1:128.
// RULE11: timer-owned prescaler is zeroed by every count write, assignment kept.
// RULE12: watchdog-owned prescaler is zeroed with the watchdog by the clear instruction.
// RULE13: assignment may change at any time without a reset.
// RULE14: software uses a safe sequence when moving prescaler from timer to watchdog.
// RULE15: overflow flag is bit 2, its request masked while bit 5 is clear; the overflow status bit still raises irq through the event mask.
// RULE16: software clears the overflow flag before enabling the interrupt again.
// RULE17: the timer halts during sleep, so its overflow never wakes the core.
// RULE18: timer-owned prescaler advances the count once per completed ratio.
package tmr_pkg;
    // ==================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'h0B;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_EVT_STATUS = 8'hC0;
    localparam logic [7:0] IDX_EVT_MASK = 8'hC1;
    // ==================================================
    // field positions and reset values
    localparam int OPT_CS_BIT = 5;
    localparam int OPT_SE_BIT = 4;
    localparam int OPT_PSA_BIT = 3;
    localparam int IRQC_FLAG_BIT = 2;
    localparam int IRQC_EN_BIT = 5;
    localparam int EVT_OVF_BIT = 0;
    localparam int EVT_EDGE_BIT = 1;
    localparam logic [7:0] OPT_RESET = 8'hFF;
    localparam logic [7:0] IRQC_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] EVT_RESET = 2'h0;
    // ==================================================
    // timing counts in instruction cycles
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
    // ==================================================
    // state of the block
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] option;
        logic [7:0] irqc;
        logic [1:0] evt_status;
        logic [1:0] evt_mask;
        logic [7:0] pscale;
        logic [1:0] inhibit;
        logic [1:0] pin_sync;
        logic pin_prev;
        logic waitreq;
        logic [7:0] rdata;
        logic irq;
        logic wdt_tick;
        logic wdt_clr;
    } tmr_state_t;
endpackage

// ==== design/tmr_shared_prescaler.sv ====
// timer/counter with a prescaler shared with the watchdog, Avalon-MM register slave
//
// The Avalon-MM slave port was left to the implementer.
module tmr_shared_prescaler
    import tmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_count_pin,
    input wire logic sleep_active,
    input wire logic wdt_tick_in,
    input wire logic watchdog_clear_instr,
    output logic wdt_scaled_tick,
    output logic watchdog_clear,
    output logic irq
);

    // ==================================================
    // helpers
    // prescaler fires when the masked low bits are all ones
    function automatic logic [7:0] scale_mask(input logic to_wdt, input logic [2:0] ratio);
        logic [8:0] m;
        m = 9'h000;
        if (to_wdt)
            m = (9'h001 << ratio) - 9'h001;
        else
            m = (9'h002 << ratio) - 9'h001;
        return m[7:0];
    endfunction

    function automatic logic [7:0] reg_index(input logic [9:0] addr);
        return addr[9:2];
    endfunction

    // ==================================================
    // state
    tmr_state_t st_r;
    tmr_state_t st_nxt;

    logic acc;
    logic wr_en;
    logic rd_acc;
    logic wr_count;
    logic clk_src;
    logic scaler_assign;
    logic [2:0] scale_ratio_select;
    logic ext_edge;
    logic timer_tick;
    logic pre_in;
    logic pre_fire;
    logic advance;
    logic overflow;
    logic [7:0] idx;
    logic [7:0] rd_val;

    always_comb
    begin
        st_nxt = st_r;
        idx = reg_index(avs_address);
        // a request is served in the single cycle waitrequest sits low
        acc = (avs_read || avs_write) && !st_r.waitreq;
        wr_en = acc && avs_write && avs_byteenable[0];
        rd_acc = acc && avs_read;
        wr_count = wr_en && (idx == IDX_COUNT);
        clk_src = st_r.option[OPT_CS_BIT];
        scaler_assign = st_r.option[OPT_PSA_BIT];
        scale_ratio_select = st_r.option[2:0];

        // only the second sync stage and its delayed copy feed the edge logic
        st_nxt.pin_sync = {st_r.pin_sync[0], ext_count_pin}; // RULE6
        st_nxt.pin_prev = st_r.pin_sync[1];
        if (st_r.option[OPT_SE_BIT])
            ext_edge = st_r.pin_prev && !st_r.pin_sync[1]; // RULE5
        else
            ext_edge = !st_r.pin_prev && st_r.pin_sync[1]; // RULE5

        // source tick, stopped by sleep and by the post-write inhibit
        timer_tick = (clk_src ? ext_edge : 1'b1) && !sleep_active // RULE2 RULE4 RULE17
            && (st_r.inhibit == 2'h0); // RULE3

        // one prescaler, its input chosen by the assignment bit alone
        pre_in = scaler_assign ? wdt_tick_in : timer_tick; // RULE7 RULE13
        pre_fire = pre_in && ((st_r.pscale & scale_mask(scaler_assign, scale_ratio_select))
            == scale_mask(scaler_assign, scale_ratio_select)); // RULE9 RULE10
        if (pre_in)
            st_nxt.pscale = st_r.pscale + 8'h01;
        if (wr_count && !scaler_assign)
            st_nxt.pscale = 8'h00; // RULE11
        if (watchdog_clear_instr && scaler_assign)
            st_nxt.pscale = 8'h00; // RULE12
        st_nxt.wdt_tick = scaler_assign ? pre_fire : wdt_tick_in; // RULE10
        st_nxt.wdt_clr = watchdog_clear_instr;

        advance = scaler_assign ? timer_tick : pre_fire; // RULE18
        overflow = advance && (st_r.count == COUNT_MAX) && !wr_count; // RULE1
        if (st_r.inhibit != 2'h0)
            st_nxt.inhibit = st_r.inhibit - 2'h1;
        if (advance)
            st_nxt.count = st_r.count + 8'h01;

        // ==================================================
        // register writes; hardware set wins over a software clear
        if (wr_count)
        begin
            st_nxt.count = avs_writedata[7:0];
            st_nxt.inhibit = INHIBIT_CYCLES; // RULE3
        end
        else if (wr_en && idx == IDX_OPTION)
            st_nxt.option = avs_writedata[7:0]; // RULE13
        else if (wr_en && idx == IDX_IRQ_CTRL)
            st_nxt.irqc = avs_writedata[7:0];
        else if (wr_en && idx == IDX_EVT_MASK)
            st_nxt.evt_mask = avs_writedata[1:0];
        if (rd_acc && idx == IDX_EVT_STATUS)
            st_nxt.evt_status = EVT_RESET;
        if (overflow)
        begin
            st_nxt.irqc[IRQC_FLAG_BIT] = 1'b1; // RULE1 RULE15
            st_nxt.evt_status[EVT_OVF_BIT] = 1'b1;
        end
        if (clk_src && ext_edge)
            st_nxt.evt_status[EVT_EDGE_BIT] = 1'b1;

        // ==================================================
        // read mux; the prescaler has no index and never reads back
        if (idx == IDX_COUNT) // RULE8
            rd_val = st_r.count;
        else if (idx == IDX_OPTION)
            rd_val = st_r.option;
        else if (idx == IDX_IRQ_CTRL)
            rd_val = st_r.irqc;
        else if (idx == IDX_EVT_STATUS)
            rd_val = {6'h00, st_r.evt_status};
        else if (idx == IDX_EVT_MASK)
            rd_val = {6'h00, st_r.evt_mask};
        else
            rd_val = 8'h00;
        st_nxt.waitreq = !((avs_read || avs_write) && st_r.waitreq);
        if (avs_read && st_r.waitreq)
            st_nxt.rdata = rd_val;

        st_nxt.irq = (st_r.irqc[IRQC_FLAG_BIT] && st_r.irqc[IRQC_EN_BIT]) // RULE15
            || ((st_r.evt_status & st_r.evt_mask) != 2'h0);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_r.count <= COUNT_RESET;
            st_r.option <= OPT_RESET;
            st_r.irqc <= IRQC_RESET;
            st_r.evt_status <= EVT_RESET;
            st_r.evt_mask <= EVT_RESET;
            st_r.pscale <= 8'h00;
            st_r.inhibit <= 2'h0;
            st_r.pin_sync <= 2'h0;
            st_r.pin_prev <= 1'b0;
            st_r.waitreq <= 1'b1;
            st_r.rdata <= 8'h00;
            st_r.irq <= 1'b0;
            st_r.wdt_tick <= 1'b0;
            st_r.wdt_clr <= 1'b0;
        end
        else
            st_r <= st_nxt;
    end

    assign avs_readdata = {24'h000000, st_r.rdata};
    assign avs_waitrequest = st_r.waitreq;
    assign wdt_scaled_tick = st_r.wdt_tick;
    assign watchdog_clear = st_r.wdt_clr;
    assign irq = st_r.irq;

    // ==================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_count_written;
        wr_count;
    endsequence

    sequence s_two_quiet;
        $stable(st_r.count)[*2];
    endsequence

    a_overflow_flag_set: assert property ( // RULE1
        overflow |=> st_r.irqc[IRQC_FLAG_BIT] && st_r.count == 8'h00)
        else $error("overflow did not set the flag");

    a_timer_per_cycle: assert property ( // RULE2
        !clk_src && scaler_assign && !sleep_active && st_r.inhibit == 2'h0 && !wr_count
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("timer mode missed an increment");

    a_write_inhibit_two: assert property ( // RULE3
        s_count_written |=> (st_r.inhibit == INHIBIT_CYCLES) ##1 s_two_quiet)
        else $error("count moved inside the write inhibit");

    a_ext_edge_count: assert property ( // RULE4
        clk_src && scaler_assign && ext_edge && !sleep_active && st_r.inhibit == 2'h0
        && !wr_count |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("external edge not counted");

    a_no_edge_hold: assert property ( // RULE6
        clk_src && scaler_assign && !ext_edge && !wr_count |=> $stable(st_r.count))
        else $error("counter moved without a synchronised edge");

    a_edge_polarity: assert property ( // RULE5
        clk_src && ext_edge |-> (st_r.pin_sync[1] != st_r.option[OPT_SE_BIT]))
        else $error("wrong edge polarity counted");

    a_wdt_tick_owner: assert property ( // RULE7
        !scaler_assign && !$past(scaler_assign) |=> st_r.wdt_tick == $past(wdt_tick_in))
        else $error("prescaler leaked into watchdog path");

    a_timer_ratio_gate: assert property ( // RULE9
        !scaler_assign && !wr_count && (st_r.pscale[0] == 1'b0)
        |=> $stable(st_r.count))
        else $error("timer advanced before the prescale ratio completed");

    a_wdt_one_to_one: assert property ( // RULE10
        scaler_assign && scale_ratio_select == 3'h0 && wdt_tick_in |=> st_r.wdt_tick)
        else $error("watchdog 1:1 ratio dropped a tick");

    a_write_clears_scale: assert property ( // RULE11
        wr_count && !scaler_assign |=> st_r.pscale == 8'h00 && $stable(st_r.option))
        else $error("count write did not zero the prescaler");

    a_wdt_clear_scale: assert property ( // RULE12
        watchdog_clear_instr && scaler_assign |=> st_r.pscale == 8'h00 && watchdog_clear)
        else $error("watchdog clear did not zero the prescaler");

    a_irq_masked: assert property ( // RULE15
        ##1 (irq == ($past(st_r.irqc[IRQC_FLAG_BIT] && st_r.irqc[IRQC_EN_BIT])
        || $past((st_r.evt_status & st_r.evt_mask) != 2'h0))))
        else $error("interrupt output disagrees with flag and enable");

    a_sleep_halts: assert property ( // RULE17
        sleep_active && !wr_count |=> $stable(st_r.count))
        else $error("timer counted during sleep");

    // ==================================================
    // prescaler, count, edge, register and flag checks that do not lean on the mask function
    sequence s_timer_fire;
        !scaler_assign && pre_fire && !wr_count;
    endsequence

    sequence s_step_one;
        st_r.count == $past(st_r.count) + 8'h01;
    endsequence

    a_ratio_advance: assert property ( // RULE18
        s_timer_fire |=> s_step_one)
        else $error("completed prescale ratio did not advance the count");

    a_timer_full_ratio: assert property ( // RULE9
        !scaler_assign && scale_ratio_select == 3'h7 && pre_fire
        |-> st_r.pscale == 8'hFF)
        else $error("timer 1:256 ratio fired early");

    a_timer_half_ratio: assert property ( // RULE9
        !scaler_assign && scale_ratio_select == 3'h0 && pre_fire |-> st_r.pscale[0])
        else $error("timer 1:2 ratio fired early");

    a_wdt_max_ratio: assert property ( // RULE10
        scaler_assign && scale_ratio_select == 3'h7 && pre_fire
        |-> st_r.pscale[6:0] == 7'h7F)
        else $error("watchdog 1:128 ratio fired early");

    a_wdt_idle_quiet: assert property ( // RULE10
        scaler_assign && !wdt_tick_in |=> !st_r.wdt_tick)
        else $error("scaled watchdog tick without an input tick");

    a_wdt_scale_hold: assert property ( // RULE7
        scaler_assign && !wdt_tick_in && !watchdog_clear_instr |=> $stable(st_r.pscale))
        else $error("watchdog-owned prescaler moved without a watchdog tick");

    a_timer_scale_hold: assert property ( // RULE7
        !scaler_assign && !timer_tick && !wr_count |=> $stable(st_r.pscale))
        else $error("timer-owned prescaler moved without a timer tick");

    a_count_ignores_wdt: assert property ( // RULE7
        scaler_assign && !timer_tick && !wr_count |=> $stable(st_r.count))
        else $error("count moved while the prescaler served the watchdog");

    a_inhibit_scale_hold: assert property ( // RULE3
        st_r.inhibit != 2'h0 && !scaler_assign && !wr_count |=> $stable(st_r.pscale))
        else $error("prescaler ticked inside the write inhibit");

    a_sleep_scale_hold: assert property ( // RULE17
        sleep_active && !scaler_assign && !wr_count |=> $stable(st_r.pscale))
        else $error("timer prescaler ticked during sleep");

    a_timer_mode_stop: assert property ( // RULE2
        !clk_src && scaler_assign && !wr_count && (sleep_active || st_r.inhibit != 2'h0)
        |=> $stable(st_r.count))
        else $error("timer mode counted while stopped");

    a_counter_scale_hold: assert property ( // RULE4
        clk_src && !scaler_assign && !ext_edge && !wr_count |=> $stable(st_r.pscale))
        else $error("counter mode prescaler moved without a pin edge");

    a_falling_edge_only: assert property ( // RULE5
        clk_src && st_r.option[OPT_SE_BIT] && ext_edge |-> !st_r.pin_sync[1] && st_r.pin_prev)
        else $error("falling edge mode took a rising edge");

    a_sync_change: assert property ( // RULE6
        ext_edge |-> st_r.pin_sync[1] != st_r.pin_prev)
        else $error("edge seen without a synchronised level change");

    a_option_write: assert property ( // RULE13
        wr_en && idx == IDX_OPTION |=> st_r.option == $past(avs_writedata[7:0]))
        else $error("option write did not land");

    a_count_write_load: assert property ( // RULE3
        wr_count |=> st_r.count == $past(avs_writedata[7:0]))
        else $error("count write did not load the value");

    a_wrap_to_zero: assert property ( // RULE1
        advance && st_r.count == COUNT_MAX && !wr_count
        |=> st_r.count == 8'h00 && st_r.evt_status[EVT_OVF_BIT])
        else $error("wrap did not reach zero with the status bit set");

    a_flag_only_wrap: assert property ( // RULE1
        !st_r.irqc[IRQC_FLAG_BIT] && !overflow && !(wr_en && idx == IDX_IRQ_CTRL)
        |=> !st_r.irqc[IRQC_FLAG_BIT])
        else $error("overflow flag rose without a wrap");

    a_status_sticky: assert property ( // RULE1
        st_r.evt_status[EVT_OVF_BIT] && !(rd_acc && idx == IDX_EVT_STATUS)
        |=> st_r.evt_status[EVT_OVF_BIT])
        else $error("overflow status dropped without a read");

    a_flag_held: assert property ( // RULE15
        st_r.irqc[IRQC_FLAG_BIT] && !(wr_en && idx == IDX_IRQ_CTRL)
        |=> st_r.irqc[IRQC_FLAG_BIT])
        else $error("overflow flag cleared by hardware");

    a_irq_enable_mask: assert property ( // RULE15
        !st_r.irqc[IRQC_EN_BIT] && ((st_r.evt_status & st_r.evt_mask) == 2'h0) |=> !irq)
        else $error("interrupt raised while masked");

    a_irq_flag_raise: assert property ( // RULE15
        st_r.irqc[IRQC_FLAG_BIT] && st_r.irqc[IRQC_EN_BIT] |=> irq)
        else $error("enabled overflow flag did not raise the interrupt");

    a_clear_pulse: assert property ( // RULE12
        !watchdog_clear_instr |=> !watchdog_clear)
        else $error("watchdog clear without the clear instruction");

endmodule

// ==== tb/ext_count_source.sv ====
// model of the external clock source that drives the count pin
module ext_count_source
(
    input wire logic clk_sys,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'h0;

    // ==================================================
    // edge generator
    // each level is held whole clock cycles so the two-flop synchroniser sees every one
    task automatic toggle(input int n, input int hold);
        repeat (n)
        begin
            repeat (hold) @(posedge clk_sys);
            pin <= ~pin;
        end
    endtask
endmodule

// ==== tb/tmr_shared_prescaler_test.sv ====
// self-checking bench for the shared-prescaler timer over its register bus
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tmr_shared_prescaler_test;
    import tmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, ext_count_pin;
    logic sleep_active, wdt_tick_in, watchdog_clear_instr, wdt_scaled_tick, watchdog_clear, irq;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    int n_errors = 0;
    int n_tests = 0;
    int n_wdt = 0;
    tmr_shared_prescaler tmr_shared_prescaler_inst (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_count_pin(ext_count_pin), .sleep_active(sleep_active), .wdt_tick_in(wdt_tick_in),
        .watchdog_clear_instr(watchdog_clear_instr), .wdt_scaled_tick(wdt_scaled_tick),
        .watchdog_clear(watchdog_clear), .irq(irq));
    ext_count_source ext_count_source_inst (.clk_sys(clk_sys), .pin(ext_count_pin));
    // ==================================================
    // bus access: request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v,
        input logic [3:0] be, output logic [31:0] d);
        int k;
        @(posedge clk_sys);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h000000, v};
        avs_byteenable <= be;
        avs_read <= ~w;
        avs_write <= w;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (avs_waitrequest !== 1'h0 && k < 50);
        if (avs_waitrequest !== 1'h0)
            n_errors++;
        d = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] be);
        logic [31:0] d;
        acc(1'h1, idx, v, be, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        acc(1'h0, idx, 8'h00, 4'hF, d);
        `CHK(nm, exp, d)
    endtask
    // the timer only moves while awake, so awake spans give exact counts
    task automatic run_awake(input int k);
        sleep_active <= 1'h0;
        repeat (k) @(posedge clk_sys);
        sleep_active <= 1'h1;
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(negedge clk_sys);
        `CHK("irq", exp, irq)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==================================================
    // clock, watchdog tick count, timeout
    initial
    begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (wdt_scaled_tick === 1'h1)
            n_wdt <= n_wdt + 1;
    initial
    begin
        #100000;
        n_errors++;
        finish_test();
    end
    // ==================================================
    // tests
    initial
    begin
        rst = 1'h1;
        {avs_read, avs_write, wdt_tick_in, watchdog_clear_instr} = 4'h0;
        avs_address = 10'h000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        sleep_active = 1'h1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        rdc(IDX_OPTION, 32'h000000FF, "option reset");
        rdc(IDX_COUNT, 32'h00000000, "count reset");
        rdc(IDX_IRQ_CTRL, 32'h00000000, "irq_control reset");
        wr(IDX_OPTION, 8'h08, 4'h0);
        rdc(IDX_OPTION, 32'h000000FF, "option lane off");
        rdc(8'h05, 32'h00000000, "unmapped");
        wr(IDX_OPTION, 8'h08, 4'hF);
        wr(IDX_COUNT, 8'hFE, 4'hF);
        run_awake(5);
        rdc(IDX_COUNT, 32'h00000001, "count after wrap");
        rdc(IDX_COUNT, 32'h00000001, "count asleep");
        rdc(IDX_IRQ_CTRL, 32'h00000004, "overflow flag");
        irq_is(1'h0);
        wr(IDX_EVT_MASK, 8'h01, 4'hF);
        irq_is(1'h1);
        rdc(IDX_EVT_STATUS, 32'h00000001, "status overflow");
        irq_is(1'h0);
        rdc(IDX_EVT_STATUS, 32'h00000000, "status cleared");
        wr(IDX_IRQ_CTRL, 8'h24, 4'hF);
        irq_is(1'h1);
        wr(IDX_IRQ_CTRL, 8'h20, 4'hF);
        irq_is(1'h0);
        // seven toggles give four edges of the chosen kind, as each pass starts from the level that kind of edge leaves
        for (int f = 0; f < 2; f++)
        begin
            wr(IDX_OPTION, (f == 0) ? 8'h28 : 8'h38, 4'hF);
            wr(IDX_COUNT, 8'h00, 4'hF);
            sleep_active <= 1'h0;
            ext_count_source_inst.toggle(7, (f == 0) ? 6 : 3);
            repeat (8) @(posedge clk_sys);
            sleep_active <= 1'h1;
            rdc(IDX_COUNT, 32'h00000004, "pin edges");
        end
        rdc(IDX_EVT_STATUS, 32'h00000002, "status edge");
        // half a period of slack on top of two periods, after the two inhibited cycles, absorbs up to half a period of lost ticks
        for (int r = 0; r < 8; r++)
        begin
            wr(IDX_OPTION, 8'(r), 4'hF);
            wr(IDX_COUNT, 8'h00, 4'hF);
            run_awake(2 + 2 * (2 << r) + (1 << r));
            rdc(IDX_COUNT, 32'h00000002, "prescaled count");
        end
        for (int r = 0; r < 4; r++)
        begin
            // move to the watchdog first, then clear so no stale count leaks through
            wr(IDX_OPTION, 8'h08 | 8'(r), 4'hF);
            watchdog_clear_instr <= 1'h1;
            @(posedge clk_sys);
            watchdog_clear_instr <= 1'h0;
            @(negedge clk_sys);
            `CHK("watchdog clear", 1'h1, watchdog_clear)
            @(posedge clk_sys);
            n_wdt = 0;
            repeat (3 << r)
            begin
                @(posedge clk_sys);
                wdt_tick_in <= 1'h1;
                @(posedge clk_sys);
                wdt_tick_in <= 1'h0;
            end
            repeat (4) @(posedge clk_sys);
            `CHK("scaled ticks", 3, n_wdt)
        end
        finish_test();
    end
endmodule
